// ### core/hfem_top.sv
// Purpose: Hybrid deviation monitor between motor and load encoders
// Assumes: AHB-Lite slave alone on its bus; pulse inputs synchronous
// Notes: Reads take one wait state, writes none
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module hfem_top #(
	parameter int unsigned MOT_RES = hfem_pkg::MOT_RES_DEF, // Motor counts per turn
	parameter int unsigned ZWIN = hfem_pkg::ZWIN_DEF // Load counts per index
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Motor encoder pulses
	input wire logic mot_step,
	input wire logic mot_dir,
	// Load encoder lines
	input wire logic ext_a,
	input wire logic ext_b,
	input wire logic ext_z,
	// Error flags
	output logic hyb_err,
	output logic z_break
);
	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic inv; // Load direction reversal
		logic zoff; // Index check disable
		logic [27:0] lim; // Allowed difference
		logic [6:0] rot; // Rotations between clears
		logic [20:0] num; // Ratio numerator
		logic [20:0] den; // Ratio denominator
		logic signed [31:0] dev; // Hybrid difference
		logic herr; // Excess deviation flag
		logic zbrk; // Index loss flag
		logic [31:0] pcnt; // Motor counts in this turn
		logic [6:0] rcnt; // Turns since last clear
		logic wr_p; // Write data phase pending
		logic rd_p; // Read wait pending
		logic [15:0] idx; // Captured register index
		logic [31:0] rdata; // Read data
	} hfem_top_t;
	hfem_top_t s_r, s_nxt;

	hfem_pulse_if q_if (); // Decoded load pulses
	hfem_pulse_if s_if (); // Direction-corrected load pulses
	hfem_pulse_if o_if (); // Scaled load pulses

	logic zb; // Index loss event
	logic take; // Address phase accepted
	logic clr; // Periodic clear event
	logic over; // Difference beyond limit
	logic [31:0] dabs; // Magnitude of difference
	logic [20:0] enum_v; // Effective numerator
	logic signed [31:0] dlt; // Difference change this cycle
	logic [1:0] stat_wr; // Write-one-clear strobes for the status flags

	////////////////////////////////////////////////////////////////////////////
	// Sub-blocks
	// Quadrature decode and index-loss watch on the load encoder
	hfem_quad #(.ZWIN(ZWIN)) u_quad (
		.sys_clk(sys_clk),
		.rst(rst),
		.ext_a(ext_a),
		.ext_b(ext_b),
		.ext_z(ext_z),
		.chk_en(!s_r.zoff),
		.q(q_if.src),
		.zbrk(zb)
	);

	// Counting up is counterclockwise unless reversed
	assign s_if.step = q_if.step;
	assign s_if.dir = q_if.dir ^ s_r.inv;

	// Ratio scaling of the corrected load stream
	hfem_scale u_scale (
		.sys_clk(sys_clk),
		.rst(rst),
		.num(enum_v),
		.den(s_r.den),
		.i(s_if.snk),
		.o(o_if.src)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read decode
	function automatic logic [31:0] rd_mux(input hfem_top_t s);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (s.idx)
			hfem_pkg::IDX_NUM: v = {11'h000, s.num};
			hfem_pkg::IDX_DEN: v = {11'h000, s.den};
			hfem_pkg::IDX_INV: v = {31'h00000000, s.inv};
			hfem_pkg::IDX_ZOFF: v = {31'h00000000, s.zoff};
			hfem_pkg::IDX_LIM: v = {4'h0, s.lim};
			hfem_pkg::IDX_ROT: v = {25'h0000000, s.rot};
			hfem_pkg::IDX_STAT: v = {30'h00000000, s.zbrk, s.herr};
			hfem_pkg::IDX_DEV: v = s.dev;
			default: v = 32'h00000000;
		endcase
		return v;
	endfunction : rd_mux

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		// Zero numerator takes the motor resolution
		enum_v = (s_r.num == 21'h000000) ? 21'(MOT_RES) : s_r.num;
		take = hsel && htrans[1] && hready;
		// Status write-one-clear strobes, bit order as in the status word
		stat_wr = (s_r.wr_p && (s_r.idx == hfem_pkg::IDX_STAT))
			? {hwdata[hfem_pkg::ST_ZBRK], hwdata[hfem_pkg::ST_HERR]} : 2'h0;
		// Magnitude compare against the limit
		dabs = s_r.dev[31] ? 32'(-s_r.dev) : 32'(s_r.dev);
		over = dabs > {4'h0, s_r.lim};
		// Motor counts up on counterclockwise, load scaled pulses subtract
		dlt = 32'sh00000000;
		// Both encoders counting the same way in one cycle leaves the difference unchanged
		if (mot_step) begin
			dlt = mot_dir ? dlt + 32'sh00000001 : dlt - 32'sh00000001;
		end
		if (o_if.step) begin
			dlt = o_if.dir ? dlt - 32'sh00000001 : dlt + 32'sh00000001;
		end
		// Whole-turn tracking for the periodic clear
		// Travel in either direction advances the turn count
		clr = mot_step && (s_r.rot != 7'h00) && (s_r.pcnt == 32'(MOT_RES - 1))
			&& (s_r.rcnt == s_r.rot - 7'h01);
		if (s_r.rot == 7'h00) begin
			s_nxt.pcnt = 32'h00000000;
			s_nxt.rcnt = 7'h00;
		end else if (mot_step) begin
			if (s_r.pcnt == 32'(MOT_RES - 1)) begin
				s_nxt.pcnt = 32'h00000000;
				s_nxt.rcnt = clr ? 7'h00 : s_r.rcnt + 7'h01;
			end else begin
				s_nxt.pcnt = s_r.pcnt + 32'h00000001;
			end
		end
		// Difference update or clear
		if (clr) begin
			s_nxt.dev = 32'sh00000000;
		end else begin
			s_nxt.dev = s_r.dev + dlt;
		end
		// Bus data phase: writes
		s_nxt.wr_p = take && hwrite;
		s_nxt.rd_p = take && !hwrite;
		if (take) begin
			s_nxt.idx = haddr[17:2];
		end
		// Out-of-range settings clamp rather than being refused, so a stray
		// write still leaves a usable limit and ratio behind
		if (s_r.wr_p) begin
			unique case (s_r.idx)
				hfem_pkg::IDX_NUM: begin
					s_nxt.num = (hwdata > {11'h000, hfem_pkg::NUM_MAX})
						? hfem_pkg::NUM_MAX : hwdata[20:0];
				end
				hfem_pkg::IDX_DEN: begin
					if (hwdata == 32'h00000000) begin
						s_nxt.den = 21'h000001;
					end else if (hwdata > {11'h000, hfem_pkg::NUM_MAX}) begin
						s_nxt.den = hfem_pkg::NUM_MAX;
					end else begin
						s_nxt.den = hwdata[20:0];
					end
				end
				hfem_pkg::IDX_INV: s_nxt.inv = hwdata[0];
				hfem_pkg::IDX_ZOFF: s_nxt.zoff = hwdata[0];
				hfem_pkg::IDX_LIM: begin
					if (hwdata == 32'h00000000) begin
						s_nxt.lim = 28'h0000001;
					end else if (hwdata > {4'h0, hfem_pkg::LIM_MAX}) begin
						s_nxt.lim = hfem_pkg::LIM_MAX;
					end else begin
						s_nxt.lim = hwdata[27:0];
					end
				end
				hfem_pkg::IDX_ROT: begin
					s_nxt.rot = (hwdata > {25'h0000000, hfem_pkg::ROT_MAX})
						? hfem_pkg::ROT_MAX : hwdata[6:0];
					s_nxt.pcnt = 32'h00000000;
					s_nxt.rcnt = 7'h00;
				end
				hfem_pkg::IDX_STAT: begin
					// Write one clears a flag
					if (hwdata[hfem_pkg::ST_HERR]) begin
						s_nxt.herr = 1'b0;
					end
					if (hwdata[hfem_pkg::ST_ZBRK]) begin
						s_nxt.zbrk = 1'b0;
					end
				end
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end
		// Events set after the clear so that a set wins
		if (over) begin
			s_nxt.herr = 1'b1;
		end
		if (zb) begin
			s_nxt.zbrk = 1'b1;
		end
		// Bus data phase: reads load data during the wait cycle
		if (s_r.rd_p) begin
			s_nxt.rdata = rd_mux(s_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	// Limit and denominator leave reset at their defaults, all else at zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.lim <= hfem_pkg::LIM_RST;
			s_r.den <= hfem_pkg::DEN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// Sticky flags and read data come straight from flip-flops
	// Transfer size is not decoded: every register is one whole word
	assign hreadyout = !s_r.rd_p; // One wait state on reads
	assign hresp = 1'b0; // Always OKAY
	assign hrdata = s_r.rdata;
	assign hyb_err = s_r.herr;
	assign z_break = s_r.zbrk;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// A read answers after exactly one wait cycle
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_read_wait: assert property (take && !hwrite |=> rd_wait)
		else $error("read wait state wrong");
	a_limit_flag: assert property (over |=> hyb_err)
		else $error("deviation flag missed");
	a_flag_cause: assert property ($rose(hyb_err) |-> $past(over))
		else $error("deviation flag without cause");
	a_period_clear: assert property (clr |=> s_r.dev == 32'sh00000000)
		else $error("periodic clear missed");
	a_clear_off: assert property (s_r.rot == 7'h00 |-> !clr)
		else $error("clear while disabled");
	a_num_auto: assert property (s_r.num == 21'h000000 |-> enum_v == 21'(MOT_RES))
		else $error("numerator default wrong");
	a_dir_invert: assert property (q_if.step && s_r.inv |-> s_if.dir == !q_if.dir)
		else $error("reversal not applied");
	a_dir_ccw: assert property (q_if.step && !s_r.inv |-> s_if.dir == q_if.dir)
		else $error("uninverted direction wrong");
	a_zbrk_off: assert property (s_r.zoff && !z_break |=> !z_break)
		else $error("index flag while check off");
	a_dev_hold: assert property (!mot_step && !o_if.step && !clr |=> $stable(s_r.dev))
		else $error("difference moved idle");
	// Flags hold until a write of one clears them; an event keeps them set
	a_err_sticky: assert property (hyb_err && !stat_wr[0] |=> hyb_err)
		else $error("deviation flag dropped");
	a_zloss_sticky: assert property (z_break && !stat_wr[1] |=> z_break)
		else $error("index flag dropped");
	a_zloss_flag: assert property (zb |=> z_break)
		else $error("index loss flag missed");
	a_turn_count: assert property (s_r.rot != 7'h00 |-> s_r.rcnt < s_r.rot)
		else $error("turn count past setting");
endmodule : hfem_top
`default_nettype wire

// ### core/hfem_pkg.sv
// Purpose: Shared constants of the hybrid feedback error monitor
// Assumes: Word registers on AHB-Lite, byte address = 4 x index
// Notes: Indices kept as printed; status and readback indices added
package hfem_pkg;
	// Register indices
	localparam logic [15:0] IDX_NUM = 16'h3324;
	localparam logic [15:0] IDX_DEN = 16'h3325;
	localparam logic [15:0] IDX_INV = 16'h3326;
	localparam logic [15:0] IDX_ZOFF = 16'h3327;
	localparam logic [15:0] IDX_LIM = 16'h3328;
	localparam logic [15:0] IDX_ROT = 16'h3329;
	localparam logic [15:0] IDX_STAT = 16'h3330;
	localparam logic [15:0] IDX_DEV = 16'h3331;
	// Status field positions
	localparam int ST_HERR = 0;
	localparam int ST_ZBRK = 1;
	// Reset values and setting ranges
	localparam logic [27:0] LIM_RST = 28'h0003E80;
	localparam logic [27:0] LIM_MAX = 28'h8000000;
	localparam logic [6:0] ROT_MAX = 7'h64;
	localparam logic [20:0] NUM_MAX = 21'h100000;
	localparam logic [20:0] DEN_RST = 21'h002710;
	// Default counts per motor turn and index search window
	localparam int unsigned MOT_RES_DEF = 1048576;
	localparam int unsigned ZWIN_DEF = 4194304;
endpackage : hfem_pkg

// ### core/hfem_pulse_if.sv
// Purpose: Signed pulse stream between monitor blocks
// Assumes: One-cycle step strobe, dir high counts up
// Notes: None
`timescale 1ns/10ps
`default_nettype none
interface hfem_pulse_if;
	logic step; // One-cycle count strobe
	logic dir; // High counts up
	modport src (output step, output dir);
	modport snk (input step, input dir);
endinterface : hfem_pulse_if
`default_nettype wire

// ### core/hfem_quad.sv
// Purpose: Quadrature decode of the load encoder with index loss check
// Assumes: A, B, Z synchronous to sys_clk
// Notes: Up count when A leads B
`timescale 1ns/10ps
`default_nettype none
module hfem_quad #(
	parameter int unsigned ZWIN = hfem_pkg::ZWIN_DEF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Encoder lines
	input wire logic ext_a,
	input wire logic ext_b,
	input wire logic ext_z,
	// Control and result
	input wire logic chk_en,
	hfem_pulse_if.src q,
	output logic zbrk
);
	typedef struct packed {
		logic pa; // Previous A
		logic pb; // Previous B
		logic pz; // Previous Z
		logic [31:0] cnt; // Counts since last index
	} hfem_quad_t;
	hfem_quad_t s_r, s_nxt;
	// Decode, window count and index check
	always_comb begin
		s_nxt = s_r;
		s_nxt.pa = ext_a;
		s_nxt.pb = ext_b;
		s_nxt.pz = ext_z;
		q.step = (ext_a ^ s_r.pa) ^ (ext_b ^ s_r.pb);
		q.dir = ext_a ^ s_r.pb;
		zbrk = chk_en && (s_r.cnt >= 32'(ZWIN));
		if (ext_z && !s_r.pz || zbrk || !chk_en) begin
			s_nxt.cnt = 32'h00000000;
		end else if (q.step) begin
			s_nxt.cnt = s_r.cnt + 32'h00000001;
		end
	end
	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	a_zchk_off: assert property (@(posedge sys_clk) disable iff (rst)
		!chk_en |-> !zbrk) else $error("index check fired while off");
endmodule : hfem_quad
`default_nettype wire

// ### core/hfem_scale.sv
// Purpose: Ratio scaler from load pulses to motor-equivalent pulses
// Assumes: den nonzero
// Notes: Emits at most one pulse a cycle; remainder stays in the accumulator
`timescale 1ns/10ps
`default_nettype none
module hfem_scale (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Ratio
	input wire logic [20:0] num,
	input wire logic [20:0] den,
	// Streams
	hfem_pulse_if.snk i,
	hfem_pulse_if.src o
);
	typedef struct packed {
		logic signed [31:0] acc; // Scaled backlog
	} hfem_scale_t;
	hfem_scale_t s_r, s_nxt;
	logic signed [31:0] sum;
	logic signed [31:0] dn;
	// Add num per input pulse, drain den per output pulse
	always_comb begin
		dn = signed'({11'h000, den});
		sum = s_r.acc;
		if (i.step) begin
			sum = i.dir ? s_r.acc + signed'({11'h000, num})
				: s_r.acc - signed'({11'h000, num});
		end
		s_nxt.acc = sum;
		o.step = 1'b0;
		o.dir = 1'b0;
		if (sum >= dn) begin
			o.step = 1'b1;
			o.dir = 1'b1;
			s_nxt.acc = sum - dn;
		end else if (sum <= -dn) begin
			o.step = 1'b1;
			s_nxt.acc = sum + dn;
		end
	end
	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	a_scale_up: assert property (@(posedge sys_clk) disable iff (rst)
		o.step && o.dir |=> s_r.acc == $past(sum) - $past(dn))
		else $error("scaler drain wrong");
endmodule : hfem_scale
`default_nettype wire

// ### dv/hfem_enc_model.sv
// Purpose: Load encoder model driving quadrature and index lines
// Assumes: Lines change by non-blocking assignment just after a rising edge
// Notes: One count every two cycles; index pulse on every fourth count when enabled
`timescale 1ns/10ps
`default_nettype none
module hfem_enc_model (
	// Clock
	input wire logic sys_clk,
	// Encoder lines
	output logic ext_a,
	output logic ext_b,
	output logic ext_z
);
	logic [1:0] ph_r; // Quadrature phase
	logic [7:0] pos_r; // Shaft position in counts
	logic z_on; // Index pulses enabled
	////////////////////////////////////////////////////////////////////////
	// Idle lines at time zero
	initial begin
		ph_r = 2'h0;
		pos_r = 8'h00;
		z_on = 1'b0;
		ext_a = 1'b0;
		ext_b = 1'b0;
		ext_z = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Move n counts; up has A leading B, as for a CCW shaft
	task automatic move(input int n, input logic up);
		repeat (n) begin
			ph_r = up ? ph_r + 2'h1 : ph_r - 2'h1;
			pos_r = up ? pos_r + 8'h01 : pos_r - 8'h01;
			ext_a <= (ph_r == 2'h1) || (ph_r == 2'h2);
			ext_b <= ph_r[1];
			ext_z <= z_on && (pos_r[1:0] == 2'h0);
			repeat (2) @(posedge sys_clk);
		end
	endtask : move
	// Back to phase zero with lines low, so no false edge follows a reset
	task automatic home;
		ph_r = 2'h0;
		pos_r = 8'h00;
		ext_a <= 1'b0;
		ext_b <= 1'b0;
		ext_z <= 1'b0;
	endtask : home
endmodule : hfem_enc_model
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench of the hybrid deviation monitor
// Assumes: Small counts per turn (8) and index window (16)
// Notes: Every scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// Bus and pins
	logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, mot_step, mot_dir;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic hyb_err, z_break, ext_a, ext_b, ext_z;
	int err_total, check_count, cyc;
	////////////////////////////////////////////////////////////////////////
	// Design and load encoder
	hfem_top #(.MOT_RES(8), .ZWIN(16)) u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mot_step(mot_step), .mot_dir(mot_dir), .ext_a(ext_a), .ext_b(ext_b),
		.ext_z(ext_z), .hyb_err(hyb_err), .z_break(z_break));
	hfem_enc_model u_enc (.sys_clk(sys_clk), .ext_a(ext_a), .ext_b(ext_b), .ext_z(ext_z));
	////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// One AHB single transfer; hready judged where settled, before each edge
	task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		logic ok;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {14'h0, idx, 2'h0};
		do begin
			@(negedge sys_clk) ok = hreadyout;
			@(posedge sys_clk);
		end while (ok !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge sys_clk) ok = hreadyout;
			rd = hrdata;
			@(posedge sys_clk);
		end while (ok !== 1'b1);
	endtask : bus
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr
	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		check(x, exp, what);
		check({31'h0, hresp}, 32'h0, "bus response");
	endtask : rdchk
	// Flags a few cycles after the last count
	task automatic fchk(input logic [1:0] exp, input string what);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk) check({30'h0, z_break, hyb_err}, {30'h0, exp}, what);
		@(posedge sys_clk);
	endtask : fchk
	task automatic do_reset;
		rst <= 1'b1;
		u_enc.home();
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
	endtask : do_reset
	// Motor counts, then interleaved load and motor counts
	task automatic mstep(input int n, input logic dir);
		repeat (n) begin
			mot_step <= 1'b1;
			mot_dir <= dir;
			@(posedge sys_clk);
			mot_step <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : mstep
	task automatic pair(input int n);
		repeat (n) begin
			u_enc.move(1, 1'b1);
			mstep(1, 1'b1);
		end
	endtask : pair
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		rdchk(hfem_pkg::IDX_LIM, 32'h00003E80, "limit reset");
		rdchk(hfem_pkg::IDX_INV, 32'h00000000, "invert reset");
		rdchk(hfem_pkg::IDX_ZOFF, 32'h00000000, "index reset");
		rdchk(hfem_pkg::IDX_ROT, 32'h00000000, "rotations reset");
		rdchk(hfem_pkg::IDX_NUM, 32'h00000000, "numerator reset");
		rdchk(hfem_pkg::IDX_DEN, 32'h00002710, "denominator reset");
		wr(hfem_pkg::IDX_LIM, 32'h00000000);
		rdchk(hfem_pkg::IDX_LIM, 32'h00000001, "limit floor");
		wr(hfem_pkg::IDX_LIM, 32'h08000001);
		rdchk(hfem_pkg::IDX_LIM, 32'h08000000, "limit ceiling");
		wr(hfem_pkg::IDX_ROT, 32'h000000C8);
		rdchk(hfem_pkg::IDX_ROT, 32'h00000064, "rotations ceiling");
		rdchk(16'h3340, 32'h00000000, "unmapped read");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_limit;
		do_reset();
		wr(hfem_pkg::IDX_LIM, 32'h00000008);
		mstep(8, 1'b1);
		fchk(2'h0, "at limit, no periodic clear");
		mstep(1, 1'b1);
		fchk(2'h1, "beyond limit");
		rdchk(hfem_pkg::IDX_STAT, 32'h00000001, "status error bit");
		$display("t_limit done");
	endtask : t_limit
	task automatic t_dir;
		do_reset();
		wr(hfem_pkg::IDX_NUM, 32'h00000001);
		wr(hfem_pkg::IDX_DEN, 32'h00000001);
		wr(hfem_pkg::IDX_LIM, 32'h00000006);
		pair(7);
		fchk(2'h0, "load up matches CCW motor");
		rdchk(hfem_pkg::IDX_DEV, 32'h00000000, "balanced difference");
		wr(hfem_pkg::IDX_INV, 32'h00000001);
		pair(7);
		fchk(2'h1, "reversed load count");
		$display("t_dir done");
	endtask : t_dir
	task automatic t_ratio;
		do_reset();
		wr(hfem_pkg::IDX_DEN, 32'h00000008);
		wr(hfem_pkg::IDX_LIM, 32'h00000006);
		pair(7);
		fchk(2'h0, "zero numerator uses resolution");
		$display("t_ratio done");
	endtask : t_ratio
	task automatic t_rot;
		do_reset();
		wr(hfem_pkg::IDX_ROT, 32'h00000002); // Not the smallest count
		wr(hfem_pkg::IDX_LIM, 32'h00000010);
		mstep(40, 1'b0);
		fchk(2'h0, "cleared every second turn");
		rdchk(hfem_pkg::IDX_DEV, 32'hFFFFFFF8, "difference since last clear");
		$display("t_rot done");
	endtask : t_rot
	task automatic t_index;
		do_reset();
		u_enc.move(15, 1'b1);
		fchk(2'h0, "index window not reached");
		u_enc.move(1, 1'b1);
		fchk(2'h2, "index line lost");
		wr(hfem_pkg::IDX_STAT, 32'h00000002);
		fchk(2'h0, "index flag cleared");
		wr(hfem_pkg::IDX_ZOFF, 32'h00000001);
		u_enc.move(20, 1'b0);
		fchk(2'h0, "index check off");
		do_reset();
		u_enc.z_on = 1'b1;
		u_enc.move(20, 1'b1);
		fchk(2'h0, "index pulses present");
		$display("t_index done");
	endtask : t_index
	////////////////////////////////////////////////////////////////////////
	// Verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		mot_step = 1'b0;
		mot_dir = 1'b0;
		err_total = 0;
		check_count = 0;
		do_reset();
		t_regs();
		t_limit();
		t_dir();
		t_ratio();
		t_rot();
		t_index();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
